// >>> dv/fdo_decoder_assertions.sv
/* Checker watching the opcode decoder's top ports.
 * Assumes binding to fdo_decoder on its own clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module fdo_decoder_checker (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_ins_valid,
	input wire logic [15:0] i_ins_code,
	input wire logic [7:0] i_sel_a,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_fp_fault,
	input wire logic o_ins_ready,
	input wire logic o_done,
	input wire logic o_trap,
	input wire logic [1:0] o_round_mode,
	input wire logic o_tmr_en_h,
	input wire logic o_float_fault_flag,
	input wire logic o_pready
);
	wire logic take;
	assign take = i_ce && i_ins_valid && o_ins_ready;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	a_done_pulse: assert property (o_done |=> !o_done)
		else $error("done held past one cycle");
	a_trap_with_done: assert property (o_trap |-> o_done)
		else $error("trap pulse without done");
	a_done_ready: assert property (o_done |-> o_ins_ready)
		else $error("not ready when done");
	a_memstart_one: assert property (take && i_ins_code == 16'h27FE |=> !o_done ##1 o_done)
		else $error("memory start load not one cycle");
	a_tdis_one: assert property (take && i_ins_code == 16'h27FA
		|=> !o_done ##1 (o_done && !o_tmr_en_h))
		else $error("timer disable wrong");
	a_ten_six: assert property (take && i_ins_code == 16'h27FC
		|=> !o_done [*6] ##1 (o_done && o_tmr_en_h))
		else $error("timer enable wrong");
	a_round_near: assert property (take && i_ins_code == 16'h2AFB && i_sel_a == 8'h22
		|=> !o_done [*2] ##1 (o_done && o_round_mode == 2'h0))
		else $error("round nearest selector wrong");
	a_fault_sets: assert property (i_ce && i_fp_fault |=> o_float_fault_flag)
		else $error("fault event did not set flag");
	a_apb_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
		else $error("apb wait state not one cycle");
endmodule
bind fdo_decoder fdo_decoder_checker i_fdo_decoder_checker (.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n), .i_ce(i_ce), .i_ins_valid(i_ins_valid), .i_ins_code(i_ins_code),
	.i_sel_a(i_sel_a), .i_psel(i_psel), .i_penable(i_penable), .i_fp_fault(i_fp_fault),
	.o_ins_ready(o_ins_ready), .o_done(o_done), .o_trap(o_trap),
	.o_round_mode(o_round_mode), .o_tmr_en_h(o_tmr_en_h),
	.o_float_fault_flag(o_float_fault_flag), .o_pready(o_pready));
`default_nettype wire

// >>> dv/fdo_decoder_tb_top.sv
/* Self-checking bench: instruction timing and effects, registers over APB.
 * Assumes the checker binds itself to fdo_decoder. */
`timescale 1ns/1ps
`default_nettype none
module fdo_decoder_tb_top;
	logic i_clk_sys = 1'b0, i_rst_n = 1'b0, ce = 1'b1, fault = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
	logic [7:0] paddr = 8'h00, sel;
	logic [31:0] pwdata = 32'h0, q, prdata;
	logic valid, dbl, lowp, ready, done, trap, ten_h, ten_l, ffl, tbit, pready, pslverr;
	logic [15:0] code;
	logic [1:0] rmode;
	int err_count = 0, samples_checked = 0, i;
	logic [7:0] rsel [4] = '{8'h22, 8'h06, 8'h04, 8'h05};
	logic [35:0] tbl [43] = '{36'h23FE00004, 36'h23FD00004,
		36'h21F800001, 36'h25F000001, 36'h21FC00001, 36'h21F700001, 36'h27FE00001,
		36'h000000003, 36'h2BF300001, 36'h00000000B, 36'h00000010D,
		36'h2BF200001, 36'h000000003, 36'h27FA00001, 36'h27FB00001,
		36'h27FC00006, 36'h27FD00006, 36'h28FE00002, 36'h28FA00003,
		36'h28F600004, 36'h28F200006, 36'h2AFA00008, 36'h2AF800015,
		36'h28F800002, 36'h28F400003, 36'h29FE00004, 36'h2AFB23002,
		36'h29FC00002, 36'h2AFB9C002, 36'h2AFB0E004, 36'h2AFB0F004,
		36'h2AFB0D003, 36'h2AF100005, 36'h28F700006, 36'h28F700206,
		36'h28FB0000B, 36'h28FB00212, 36'h28FC00010, 36'h28FC0021F,
		36'h28FF00024, 36'h2AFB0101C, 36'h2AFB0202B, 36'h2AFB03009};
	fdo_decoder i_fdo_decoder (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(ce),
		.i_ins_valid(valid), .i_ins_code(code), .i_sel_a(sel), .i_dbl(dbl), .i_low_pri(lowp),
		.i_fp_fault(fault), .o_ins_ready(ready), .o_done(done), .o_trap(trap),
		.o_round_mode(rmode), .o_tmr_en_h(ten_h), .o_tmr_en_l(ten_l),
		.o_float_fault_flag(ffl), .o_test_bit(tbit), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr));
	fdo_ins_src i_fdo_ins_src (.i_clk(i_clk_sys), .i_ready(ready), .i_done(done),
		.o_valid(valid), .o_code(code), .o_sel(sel), .o_dbl(dbl), .o_low_pri(lowp));
	initial begin
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk_sys);
		penable <= 1'b1;
		do begin @(posedge i_clk_sys); n++; end while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, {31'h0, pready});
		if (pready !== 1'b1) stop_test();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_clk_sys);
	endtask
	task automatic ins(input logic [35:0] t);
		int c;
		i_fdo_ins_src.send(t, c);
		chk($sformatf("cycles of %h sel %h", t[35:20], t[19:12]), {24'h0, t[7:0]}, c);
		if (c < 0) stop_test();
	endtask
	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl reset", 32'h0, q);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		$display("test registers done");
		for (i = 0; i < $size(tbl); i++) ins(tbl[i]);
		chk("timer enables", 32'h3, {30'h0, ten_l, ten_h});
		$display("test timing done");
		for (i = 0; i < 4; i++) begin
			ins({16'h2AFB, rsel[i], 12'h002});
			chk("round mode", i, {30'h0, rmode});
		end
		ins({16'h2AFB, 8'h7F, 12'h001});
		chk("round mode kept", 32'h3, {30'h0, rmode});
		apb(1'b0, 8'h04, 32'h0);
		chk("stat trap badsel", 32'hC, q);
		ins(36'h2BF300001);
		ins(36'h2BF400002);
		chk("test bit set", 32'h1, {31'h0, tbit});
		ins(36'h2BF200001);
		ins(36'h2BF400002);
		chk("test bit clear", 32'h0, {31'h0, tbit});
		@(posedge i_clk_sys);
		fault <= 1'b1;
		@(posedge i_clk_sys);
		fault <= 1'b0;
		@(negedge i_clk_sys);
		chk("fault flag", 32'h1, {31'h0, ffl});
		ins(36'h29FC00002);
		chk("fault test bit", 32'h0, {31'h0, tbit});
		chk("fault cleared", 32'h0, {31'h0, ffl});
		$display("test effects done");
		apb(1'b1, 8'h0C, 32'h0);
		apb(1'b1, 8'h00, 32'h40);
		ins(36'h28F700009);
		ins(36'h28FB0021B);
		apb(1'b0, 8'h0C, 32'h0);
		chk("done count", 32'h2, q);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl max bit", 32'h40, q);
		$display("test max timing done");
		stop_test();
	end
endmodule
`default_nettype wire

// >>> dv/fdo_ins_src.sv
/* Instruction source standing in for the processor's fetch stream.
 * Assumes the decoder's ready and done on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module fdo_ins_src (
	input wire logic i_clk,
	input wire logic i_ready,
	input wire logic i_done,
	output logic o_valid,
	output logic [15:0] o_code,
	output logic [7:0] o_sel,
	output logic o_dbl,
	output logic o_low_pri
);
	initial begin
		o_valid = 1'b0;
		o_code = 16'h5A5A;
		o_sel = 8'hA5;
		o_dbl = 1'b0;
		o_low_pri = 1'b0;
	end
	// t is code, selector, flags, count; c is cycles to done, -1 on a hang
	task automatic send(input logic [35:0] t, output int c);
		int n;
		n = 0;
		do begin @(negedge i_clk); n++; end while (i_ready !== 1'b1 && n < 200);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_code <= t[35:20];
		o_sel <= t[19:12];
		o_dbl <= t[9];
		o_low_pri <= t[8];
		@(posedge i_clk);
		o_valid <= 1'b0;
		// released lines show the inverse so stale values cannot pass
		o_code <= ~t[35:20];
		o_sel <= ~t[19:12];
		o_dbl <= ~t[9];
		o_low_pri <= ~t[8];
		c = 0;
		do begin @(negedge i_clk); c++; end while (i_done !== 1'b1 && c < 200);
		c = (i_done === 1'b1) ? c - 1 : -1;
		@(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// >>> verilog/fdo_cost.sv
/*
 * Combinational opcode table: memory code and selector to action,
 * recognition and cycle count.
 * Assumes code and selector taken unregistered from the decoder top's ports.
 */
`timescale 1ns/1ps
`default_nettype none
module fdo_cost (
	input wire logic [15:0] i_code,
	input wire logic [7:0] i_sel,
	input wire logic i_dbl,
	input wire logic i_low_pri,
	input wire logic i_brk_en,
	input wire logic i_use_max,
	output logic o_known,
	output fdo_pkg::fdo_act_e o_act,
	output logic [5:0] o_cycles
);
	// entry layout: known, action, typical, maximum
	function automatic logic [16:0] ent(input logic [3:0] a, input logic [5:0] t,
		input logic [5:0] m);
		ent = {1'b1, a, t, m};
	endfunction
	localparam logic [16:0] NONE = 17'h00000;
	logic [16:0] e;
	logic [16:0] s;
	logic [5:0] t_sum;
	logic [5:0] m_sum;
	always_comb begin
		unique case (i_sel)
		fdo_pkg::SEL_RN: s = ent(fdo_pkg::ACT_RND_N, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::SEL_RZ: s = ent(fdo_pkg::ACT_RND_Z, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::SEL_RP: s = ent(fdo_pkg::ACT_RND_P, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::SEL_RM: s = ent(fdo_pkg::ACT_RND_M, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::SEL_ERRSET: s = ent(fdo_pkg::ACT_ERR_SET, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::SEL_ERRCLR: s = ent(fdo_pkg::ACT_ERR_CLR, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::SEL_CHK32,
		fdo_pkg::SEL_CHK64: s = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_CHK_T, fdo_pkg::CY_CHK_M);
		fdo_pkg::SEL_NORND: s = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_NORND, fdo_pkg::CY_NORND);
		fdo_pkg::SEL_SQF: s = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_SQF_T, fdo_pkg::CY_SQF_M);
		fdo_pkg::SEL_SQS: s = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_SQS, fdo_pkg::CY_SQS);
		fdo_pkg::SEL_SQL: s = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_SQL_T, fdo_pkg::CY_SQL_M);
		default: s = NONE;
		endcase
	end
	// selector sequence costs the entry dispatch plus the selected operation
	assign t_sum = fdo_pkg::CY_FAST + s[11:6];
	assign m_sum = fdo_pkg::CY_FAST + s[5:0];
	always_comb begin
		unique case (i_code)
		fdo_pkg::MC_SAVEH,
		fdo_pkg::MC_SAVEL: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_SAVEQ, fdo_pkg::CY_SAVEQ);
		fdo_pkg::MC_STHF, fdo_pkg::MC_STHB, fdo_pkg::MC_STLF,
		fdo_pkg::MC_STLB: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::MC_MEMSTART: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::MC_JUMP0: e = !i_brk_en ? ent(fdo_pkg::ACT_J0, fdo_pkg::CY_J0, fdo_pkg::CY_J0) :
			i_low_pri ? ent(fdo_pkg::ACT_J0, fdo_pkg::CY_J0_L, fdo_pkg::CY_J0_L) :
			ent(fdo_pkg::ACT_J0, fdo_pkg::CY_J0_H, fdo_pkg::CY_J0_H);
		fdo_pkg::MC_BRK_CLR: e = ent(fdo_pkg::ACT_BRK_CLR, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::MC_BRK_SET: e = ent(fdo_pkg::ACT_BRK_SET, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::MC_BRK_TEST: e = ent(fdo_pkg::ACT_BRK_TEST, fdo_pkg::CY_TEST, fdo_pkg::CY_TEST);
		fdo_pkg::MC_TDIS_H: e = ent(fdo_pkg::ACT_TDIS_H, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::MC_TDIS_L: e = ent(fdo_pkg::ACT_TDIS_L, fdo_pkg::CY_FAST, fdo_pkg::CY_FAST);
		fdo_pkg::MC_TEN_H: e = ent(fdo_pkg::ACT_TEN_H, fdo_pkg::CY_TEN, fdo_pkg::CY_TEN);
		fdo_pkg::MC_TEN_L: e = ent(fdo_pkg::ACT_TEN_L, fdo_pkg::CY_TEN, fdo_pkg::CY_TEN);
		fdo_pkg::MC_LD_SN: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_LD_SN, fdo_pkg::CY_LD_SN);
		fdo_pkg::MC_LD_DB: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_LD_DB, fdo_pkg::CY_LD_DB);
		fdo_pkg::MC_LD_SNI: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_LD_SNI, fdo_pkg::CY_LD_SNI);
		fdo_pkg::MC_LD_DBI: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_LD_DBI, fdo_pkg::CY_LD_DBI);
		fdo_pkg::MC_LDADD_SN: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_LDADD_T, fdo_pkg::CY_LDADD_M);
		fdo_pkg::MC_LDMUL_DB: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_LDMUL_T, fdo_pkg::CY_LDMUL_M);
		fdo_pkg::MC_ST_SN: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_ST_SN, fdo_pkg::CY_ST_SN);
		fdo_pkg::MC_ST_DB: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_ST_DB, fdo_pkg::CY_ST_DB);
		fdo_pkg::MC_ST_I32: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_ST_I32, fdo_pkg::CY_ST_I32);
		fdo_pkg::MC_ENTRY: e = {s[16:12], t_sum, m_sum};
		fdo_pkg::MC_TESTERR: e = ent(fdo_pkg::ACT_ERR_TEST, fdo_pkg::CY_TEST, fdo_pkg::CY_TEST);
		fdo_pkg::MC_FINT: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_FINT_T, fdo_pkg::CY_FINT_M);
		fdo_pkg::MC_FADD: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_ADD_T, fdo_pkg::CY_ADD_M);
		fdo_pkg::MC_FMUL: e = i_dbl ? ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_MULD_T, fdo_pkg::CY_MULD_M) :
			ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_MULS_T, fdo_pkg::CY_MULS_M);
		fdo_pkg::MC_FDIV: e = i_dbl ? ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_DIVD_T, fdo_pkg::CY_DIVD_M) :
			ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_DIVS_T, fdo_pkg::CY_DIVS_M);
		fdo_pkg::MC_REMF: e = ent(fdo_pkg::ACT_NONE, fdo_pkg::CY_REM_T, fdo_pkg::CY_REM_M);
		default: e = NONE;
		endcase
	end
	assign o_known = e[16];
	assign o_act = fdo_pkg::fdo_act_e'(e[15:12]);
	// unknown codes still retire in one cycle
	assign o_cycles = !e[16] ? fdo_pkg::CY_FAST : i_use_max ? e[5:0] : e[11:6];
endmodule
`default_nettype wire

// >>> verilog/fdo_decoder.sv
/*
 * Opcode decoder and cycle-timing model for the debugger-support,
 * processor-initialisation and floating-point instruction groups, with
 * an APB register slave.
 * Assumes instructions arrive from logic on i_clk_sys, one at a time,
 * accepted while o_ins_ready is high; the APB master follows APB rules.
 */
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fdo_decoder #(
	parameter int DONE_W = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_ins_valid,
	input wire logic [15:0] i_ins_code,
	input wire logic [7:0] i_sel_a,
	input wire logic i_dbl,
	input wire logic i_low_pri,
	input wire logic i_fp_fault,
	output logic o_ins_ready,
	output logic o_done,
	output logic o_trap,
	output logic [1:0] o_round_mode,
	output logic o_tmr_en_h,
	output logic o_tmr_en_l,
	output logic o_float_fault_flag,
	output logic o_test_bit,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);
	if (DONE_W < 1 || DONE_W > 32) begin : g_bad_width
		$error("DONE_W must lie between 1 and 32");
	end

	typedef enum logic {ST_IDLE, ST_RUN} fdo_state_e;

	// reset synchroniser
	logic rst_q1;
	logic rst_q2;
	wire rst_n_s = rst_q2;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_q1 <= 1'b0;
			rst_q2 <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_q2 <= rst_q1;
		end
	end

	// state
	fdo_state_e state;
	logic [fdo_pkg::CYC_W-1:0] count;
	fdo_pkg::fdo_act_e act_q;
	logic known_q;
	logic brk_q;
	logic [15:0] code_q;
	logic [fdo_pkg::CYC_W-1:0] cyc_q;
	logic brk_en;
	logic [1:0] rnd;
	logic ten_h;
	logic ten_l;
	logic fault;
	logic use_max;
	logic test_bit;
	logic bad_sel;
	logic trap_seen;
	logic ready;
	logic done;
	logic trap;
	logic [DONE_W-1:0] done_cnt;
	logic pready;
	logic pslverr;
	logic [31:0] prdata;

	// table lookup
	logic c_known;
	fdo_pkg::fdo_act_e c_act;
	logic [5:0] c_cycles;
	fdo_cost u_cost (
		.i_code(i_ins_code),
		.i_sel(i_sel_a),
		.i_dbl(i_dbl),
		.i_low_pri(i_low_pri),
		.i_brk_en(brk_en),
		.i_use_max(use_max),
		.o_known(c_known),
		.o_act(c_act),
		.o_cycles(c_cycles)
	);

	// sequencing
	wire take = (state == ST_IDLE) && i_ins_valid;
	wire fin = (state == ST_RUN) && (count == fdo_pkg::CY_FAST);
	wire fin_act_n = fin && known_q;
	wire a_brk_clr = fin_act_n && (act_q == fdo_pkg::ACT_BRK_CLR);
	wire a_brk_set = fin_act_n && (act_q == fdo_pkg::ACT_BRK_SET);
	wire a_brk_test = fin_act_n && (act_q == fdo_pkg::ACT_BRK_TEST);
	wire a_tdis_h = fin_act_n && (act_q == fdo_pkg::ACT_TDIS_H);
	wire a_tdis_l = fin_act_n && (act_q == fdo_pkg::ACT_TDIS_L);
	wire a_ten_h = fin_act_n && (act_q == fdo_pkg::ACT_TEN_H);
	wire a_ten_l = fin_act_n && (act_q == fdo_pkg::ACT_TEN_L);
	wire a_rnd_n = fin_act_n && (act_q == fdo_pkg::ACT_RND_N);
	wire a_rnd_z = fin_act_n && (act_q == fdo_pkg::ACT_RND_Z);
	wire a_rnd_p = fin_act_n && (act_q == fdo_pkg::ACT_RND_P);
	wire a_rnd_m = fin_act_n && (act_q == fdo_pkg::ACT_RND_M);
	wire a_err_set = fin_act_n && (act_q == fdo_pkg::ACT_ERR_SET);
	wire a_err_clr = fin_act_n && (act_q == fdo_pkg::ACT_ERR_CLR);
	wire a_err_test = fin_act_n && (act_q == fdo_pkg::ACT_ERR_TEST);
	wire a_j0 = fin_act_n && (act_q == fdo_pkg::ACT_J0);
	wire a_bad = fin && !known_q && (code_q == fdo_pkg::MC_ENTRY);

	// APB decode
	wire apb_acc = i_psel && i_penable;
	wire apb_first = apb_acc && !pready;
	wire apb_wr = apb_acc && pready && i_pwrite;
	wire hit_ctrl = (i_paddr == fdo_pkg::REG_CTRL);
	wire hit_stat = (i_paddr == fdo_pkg::REG_STAT);
	wire hit_last = (i_paddr == fdo_pkg::REG_LAST);
	wire hit_done = (i_paddr == fdo_pkg::REG_DONE);
	wire hit = hit_ctrl || hit_stat || hit_last || hit_done;
	wire wr_ctrl = apb_wr && hit_ctrl;
	wire wr_stat = apb_wr && hit_stat;
	wire wr_done = apb_wr && hit_done;

	wire [31:0] rd_ctrl = {25'h0000000, use_max, fault, ten_l, ten_h, rnd, brk_en};
	wire [31:0] rd_stat = {28'h0000000, trap_seen, bad_sel, test_bit, state == ST_RUN};
	wire [31:0] rd_last = {10'h000, cyc_q, code_q};
	wire [31:0] rd_done = 32'(done_cnt);
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_stat ? rd_stat :
		hit_last ? rd_last :
		hit_done ? rd_done : 32'h00000000;

	// completion effects take priority over software writes
	wire next_brk_en = a_brk_set ? 1'b1 :
		a_brk_clr ? 1'b0 :
		wr_ctrl ? i_pwdata[fdo_pkg::CB_BRK] : brk_en;
	wire next_ten_h = a_ten_h ? 1'b1 :
		a_tdis_h ? 1'b0 :
		wr_ctrl ? i_pwdata[fdo_pkg::CB_TEN_H] : ten_h;
	wire next_ten_l = a_ten_l ? 1'b1 :
		a_tdis_l ? 1'b0 :
		wr_ctrl ? i_pwdata[fdo_pkg::CB_TEN_L] : ten_l;
	// unknown selectors carry ACT_NONE, so rounding holds
	wire [1:0] next_rnd = a_rnd_n ? fdo_pkg::RND_NEAR :
		a_rnd_z ? fdo_pkg::RND_ZERO :
		a_rnd_p ? fdo_pkg::RND_POS :
		a_rnd_m ? fdo_pkg::RND_NEG :
		wr_ctrl ? i_pwdata[fdo_pkg::CB_RND +: 2] : rnd;
	// a fault event from the datapath wins over any clear
	wire next_fault = (i_fp_fault || a_err_set) ? 1'b1 :
		(a_err_clr || a_err_test) ? 1'b0 :
		wr_ctrl ? i_pwdata[fdo_pkg::CB_FAULT] : fault;
	wire next_use_max = wr_ctrl ? i_pwdata[fdo_pkg::CB_MAX] : use_max;
	wire next_test_bit = a_brk_test ? brk_en :
		a_err_test ? !fault : test_bit;
	wire next_bad_sel = a_bad ? 1'b1 :
		(wr_stat && i_pwdata[fdo_pkg::SB_BADSEL]) ? 1'b0 : bad_sel;
	wire next_trap = a_j0 && brk_q;
	wire next_trap_seen = next_trap ? 1'b1 :
		(wr_stat && i_pwdata[fdo_pkg::SB_TRAP]) ? 1'b0 : trap_seen;
	wire [DONE_W-1:0] next_done_cnt = fin ? done_cnt + DONE_W'(1) :
		wr_done ? DONE_W'(0) : done_cnt;
	wire [fdo_pkg::CYC_W-1:0] next_count = take ? c_cycles :
		(state == ST_RUN) ? count - fdo_pkg::CY_FAST : count;

	// instruction sequencer
	always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			state <= ST_IDLE;
			count <= '0;
			act_q <= fdo_pkg::ACT_NONE;
			known_q <= 1'b0;
			brk_q <= 1'b0;
			ready <= 1'b0;
			done <= 1'b0;
		end else if (i_ce) begin
			count <= next_count;
			done <= fin;
			unique case (state)
			ST_IDLE: begin
				ready <= !i_ins_valid;
				if (take) begin
					state <= ST_RUN;
					act_q <= c_act;
					known_q <= c_known;
					brk_q <= brk_en;
				end
			end
			ST_RUN: begin
				if (fin) begin
					state <= ST_IDLE;
					ready <= 1'b1;
				end
			end
			endcase
		end
	end

	// record of the instruction in flight
	always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			code_q <= 16'h0000;
			cyc_q <= '0;
		end else if (i_ce && take) begin
			code_q <= i_ins_code;
			cyc_q <= c_cycles;
		end
	end

	// architectural flags
	always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			brk_en <= fdo_pkg::RST_BRK;
			rnd <= fdo_pkg::RND_NEAR;
			ten_h <= fdo_pkg::RST_TEN;
			ten_l <= fdo_pkg::RST_TEN;
			fault <= fdo_pkg::RST_FAULT;
			use_max <= fdo_pkg::RST_MAX;
		end else if (i_ce) begin
			brk_en <= next_brk_en;
			rnd <= next_rnd;
			ten_h <= next_ten_h;
			ten_l <= next_ten_l;
			fault <= next_fault;
			use_max <= next_use_max;
		end
	end

	// status and counters
	always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			test_bit <= 1'b0;
			bad_sel <= 1'b0;
			trap <= 1'b0;
			trap_seen <= 1'b0;
			done_cnt <= '0;
		end else if (i_ce) begin
			test_bit <= next_test_bit;
			bad_sel <= next_bad_sel;
			trap <= next_trap;
			trap_seen <= next_trap_seen;
			done_cnt <= next_done_cnt;
		end
	end

	// APB slave: one wait state on every access
	always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
		if (!rst_n_s) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (i_ce) begin
			pready <= apb_first;
			pslverr <= apb_first && !hit;
			prdata <= (apb_first && !i_pwrite) ? rd_mux : 32'h00000000;
		end
	end

	assign o_ins_ready = ready;
	assign o_done = done;
	assign o_trap = trap;
	assign o_round_mode = rnd;
	assign o_tmr_en_h = ten_h;
	assign o_tmr_en_l = ten_l;
	assign o_float_fault_flag = fault;
	assign o_test_bit = test_bit;
	assign o_prdata = prdata;
	assign o_pready = pready;
	assign o_pslverr = pslverr;
endmodule
`default_nettype wire

// >>> verilog/fdo_pkg.sv
/*
 * Constants for the debug, initialisation and floating-point opcode
 * decoder: register map, field positions, reset values, memory codes,
 * selector codes and cycle counts.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package fdo_pkg;
	localparam int CYC_W = 6;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_LAST = 8'h08;
	localparam logic [7:0] REG_DONE = 8'h0C;
	// control register fields
	localparam int CB_BRK = 0;
	localparam int CB_RND = 1;
	localparam int CB_TEN_H = 3;
	localparam int CB_TEN_L = 4;
	localparam int CB_FAULT = 5;
	localparam int CB_MAX = 6;
	// status register fields
	localparam int SB_BUSY = 0;
	localparam int SB_TEST = 1;
	localparam int SB_BADSEL = 2;
	localparam int SB_TRAP = 3;
	// last register fields
	localparam int LB_CYC = 16;
	// rounding modes
	localparam logic [1:0] RND_NEAR = 2'h0;
	localparam logic [1:0] RND_ZERO = 2'h1;
	localparam logic [1:0] RND_POS = 2'h2;
	localparam logic [1:0] RND_NEG = 2'h3;
	// reset values
	localparam logic RST_BRK = 1'b0;
	localparam logic RST_TEN = 1'b0;
	localparam logic RST_FAULT = 1'b0;
	localparam logic RST_MAX = 1'b0;
	// memory codes
	localparam logic [15:0] MC_SAVEH = 16'h23FE;
	localparam logic [15:0] MC_SAVEL = 16'h23FD;
	localparam logic [15:0] MC_STHF = 16'h21F8;
	localparam logic [15:0] MC_STHB = 16'h25F0;
	localparam logic [15:0] MC_STLF = 16'h21FC;
	localparam logic [15:0] MC_STLB = 16'h21F7;
	localparam logic [15:0] MC_MEMSTART = 16'h27FE;
	localparam logic [15:0] MC_JUMP0 = 16'h0000;
	localparam logic [15:0] MC_BRK_CLR = 16'h2BF2;
	localparam logic [15:0] MC_BRK_SET = 16'h2BF3;
	localparam logic [15:0] MC_BRK_TEST = 16'h2BF4;
	localparam logic [15:0] MC_TDIS_H = 16'h27FA;
	localparam logic [15:0] MC_TDIS_L = 16'h27FB;
	localparam logic [15:0] MC_TEN_H = 16'h27FC;
	localparam logic [15:0] MC_TEN_L = 16'h27FD;
	localparam logic [15:0] MC_LD_SN = 16'h28FE;
	localparam logic [15:0] MC_LD_DB = 16'h28FA;
	localparam logic [15:0] MC_LD_SNI = 16'h28F6;
	localparam logic [15:0] MC_LD_DBI = 16'h28F2;
	localparam logic [15:0] MC_LDADD_SN = 16'h2AFA;
	localparam logic [15:0] MC_LDMUL_DB = 16'h2AF8;
	localparam logic [15:0] MC_ST_SN = 16'h28F8;
	localparam logic [15:0] MC_ST_DB = 16'h28F4;
	localparam logic [15:0] MC_ST_I32 = 16'h29FE;
	localparam logic [15:0] MC_ENTRY = 16'h2AFB;
	localparam logic [15:0] MC_TESTERR = 16'h29FC;
	localparam logic [15:0] MC_FINT = 16'h2AF1;
	localparam logic [15:0] MC_FADD = 16'h28F7;
	localparam logic [15:0] MC_FMUL = 16'h28FB;
	localparam logic [15:0] MC_FDIV = 16'h28FC;
	localparam logic [15:0] MC_REMF = 16'h28FF;
	// selector codes
	localparam logic [7:0] SEL_RN = 8'h22;
	localparam logic [7:0] SEL_RZ = 8'h06;
	localparam logic [7:0] SEL_RP = 8'h04;
	localparam logic [7:0] SEL_RM = 8'h05;
	localparam logic [7:0] SEL_ERRSET = 8'h23;
	localparam logic [7:0] SEL_ERRCLR = 8'h9C;
	localparam logic [7:0] SEL_CHK32 = 8'h0E;
	localparam logic [7:0] SEL_CHK64 = 8'h0F;
	localparam logic [7:0] SEL_NORND = 8'h0D;
	localparam logic [7:0] SEL_SQF = 8'h01;
	localparam logic [7:0] SEL_SQS = 8'h02;
	localparam logic [7:0] SEL_SQL = 8'h03;
	// cycle counts, typical (T) and maximum (M)
	localparam logic [5:0] CY_FAST = 6'h01;
	localparam logic [5:0] CY_TEST = 6'h02;
	localparam logic [5:0] CY_SAVEQ = 6'h04;
	localparam logic [5:0] CY_J0 = 6'h03;
	localparam logic [5:0] CY_J0_H = 6'h0B;
	localparam logic [5:0] CY_J0_L = 6'h0D;
	localparam logic [5:0] CY_TEN = 6'h06;
	localparam logic [5:0] CY_LD_SN = 6'h02;
	localparam logic [5:0] CY_LD_DB = 6'h03;
	localparam logic [5:0] CY_LD_SNI = 6'h04;
	localparam logic [5:0] CY_LD_DBI = 6'h06;
	localparam logic [5:0] CY_LDADD_T = 6'h08;
	localparam logic [5:0] CY_LDADD_M = 6'h0B;
	localparam logic [5:0] CY_LDMUL_T = 6'h15;
	localparam logic [5:0] CY_LDMUL_M = 6'h1E;
	localparam logic [5:0] CY_ST_SN = 6'h02;
	localparam logic [5:0] CY_ST_DB = 6'h03;
	localparam logic [5:0] CY_ST_I32 = 6'h04;
	localparam logic [5:0] CY_CHK_T = 6'h03;
	localparam logic [5:0] CY_CHK_M = 6'h04;
	localparam logic [5:0] CY_NORND = 6'h02;
	localparam logic [5:0] CY_FINT_T = 6'h05;
	localparam logic [5:0] CY_FINT_M = 6'h06;
	localparam logic [5:0] CY_ADD_T = 6'h06;
	localparam logic [5:0] CY_ADD_M = 6'h09;
	localparam logic [5:0] CY_MULS_T = 6'h0B;
	localparam logic [5:0] CY_MULS_M = 6'h12;
	localparam logic [5:0] CY_MULD_T = 6'h12;
	localparam logic [5:0] CY_MULD_M = 6'h1B;
	localparam logic [5:0] CY_DIVS_T = 6'h10;
	localparam logic [5:0] CY_DIVS_M = 6'h1C;
	localparam logic [5:0] CY_DIVD_T = 6'h1F;
	localparam logic [5:0] CY_DIVD_M = 6'h2B;
	localparam logic [5:0] CY_REM_T = 6'h24;
	localparam logic [5:0] CY_REM_M = 6'h2E;
	localparam logic [5:0] CY_SQF_T = 6'h1B;
	localparam logic [5:0] CY_SQF_M = 6'h1D;
	localparam logic [5:0] CY_SQS = 6'h2A;
	localparam logic [5:0] CY_SQL_T = 6'h08;
	localparam logic [5:0] CY_SQL_M = 6'h09;
	// side effect carried out when an instruction completes
	typedef enum logic [3:0] {
		ACT_NONE, ACT_BRK_CLR, ACT_BRK_SET, ACT_BRK_TEST,
		ACT_TDIS_H, ACT_TDIS_L, ACT_TEN_H, ACT_TEN_L,
		ACT_RND_N, ACT_RND_Z, ACT_RND_P, ACT_RND_M,
		ACT_ERR_SET, ACT_ERR_CLR, ACT_ERR_TEST, ACT_J0
	} fdo_act_e;
endpackage
`default_nettype wire
